//--- hdl/dgp_defs.svh
// register offsets, field positions and reset values of the dual port block
`ifndef DGP_DEFS_SVH
`define DGP_DEFS_SVH

`define DGP_OFF_A_DATA 8'h00
`define DGP_OFF_A_DIR 8'h04
`define DGP_OFF_A_PUL 8'h08
`define DGP_OFF_B_DATA 8'h0C
`define DGP_OFF_B_DIR 8'h10
`define DGP_OFF_B_PUL 8'h14
`define DGP_OFF_STBY 8'h18
`define DGP_OFF_WAKE 8'h1C

`define DGP_RST_LATCH 8'h00
`define DGP_RST_DIR 8'h00
`define DGP_RST_PUL 8'h00
`define DGP_RST_STBY 1'h0
`define DGP_RST_WAKE 4'h0

// port a: bits 0 and 1 are open drain and have no pull-up
`define DGP_A_OD_MASK 8'h03
`define DGP_A_NOPU_MASK 8'h03

// port b pins that can stay open in forced standby
`define DGP_B_SCK_BIT 5
`define DGP_B_SIN_BIT 7

// wake register fields
`define DGP_WAKE_EIC_SCK 0
`define DGP_WAKE_EIC_SIN 1
`define DGP_WAKE_SEL_SCK 2
`define DGP_WAKE_SEL_SIN 3

`define DGP_STBY_SPL_BIT 0
`endif

//--- hdl/dgp_pkg.sv
// types shared by the dual port block
package dgp_pkg;
    typedef logic [7:0] dgp_byte_t;

    typedef enum logic [3:0] {
        DGP_REG_A_DATA,
        DGP_REG_A_DIR,
        DGP_REG_A_PUL,
        DGP_REG_B_DATA,
        DGP_REG_B_DIR,
        DGP_REG_B_PUL,
        DGP_REG_STBY,
        DGP_REG_WAKE,
        DGP_REG_NONE
    } dgp_reg_e;

    typedef struct packed {
        logic [7:0] val;
        logic [7:0] en;
        logic [7:0] pu;
    } dgp_drive_s;
endpackage

//--- hdl/dgp_sync_if.sv
// carrier between the port logic and its pin synchroniser
`timescale 1ns/100ps
interface dgp_sync_if #(
    parameter int N = 12
);
    logic [N-1:0] pin_raw;
    logic [N-1:0] pin_sync;
    modport src (output pin_raw, input pin_sync);
    modport sync (input pin_raw, output pin_sync);
endinterface

//--- hdl/dgp_pin_sync.sv
// two-stage synchroniser for the pin levels
`timescale 1ns/100ps
module dgp_pin_sync #(
    parameter int N = 12
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    dgp_sync_if.sync sif
);
    logic [N-1:0] stage1_reg;
    logic [N-1:0] stage1_next;
    logic [N-1:0] stage2_reg;
    logic [N-1:0] stage2_next;

    always_comb begin
        stage1_next = sif.pin_raw;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sif.pin_sync = stage2_reg;
endmodule

//--- hdl/dgp_top.sv
// dual general purpose port: registers, pin drive, read-back and standby forcing
`timescale 1ns/100ps
`include "dgp_defs.svh"

module dgp_top #(
    parameter int A_W = 4,
    parameter int B_W = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic READ_MODIFY_WRITE_ACCESS_I,
    input wire logic STANDBY_STOP_WATCH_I,
    input wire logic [A_W-1:0] PERIPH_A_OE_I,
    input wire logic [A_W-1:0] PERIPH_A_OUT_I,
    input wire logic [B_W-1:0] PERIPH_B_OE_I,
    input wire logic [B_W-1:0] PERIPH_B_OUT_I,
    input wire logic [A_W-1:0] PORT_A_PIN_I,
    output logic [A_W-1:0] PORT_A_PIN_O,
    output logic [A_W-1:0] PORT_A_PIN_OE_O,
    output logic [A_W-1:0] PORT_A_PULLUP_O,
    output logic [A_W-1:0] PORT_A_IN_O,
    input wire logic [B_W-1:0] PORT_B_PIN_I,
    output logic [B_W-1:0] PORT_B_PIN_O,
    output logic [B_W-1:0] PORT_B_PIN_OE_O,
    output logic [B_W-1:0] PORT_B_PULLUP_O,
    output logic [B_W-1:0] PORT_B_IN_O
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic dgp_pkg::dgp_reg_e decode(input logic [7:0] addr);
        case (addr)
            `DGP_OFF_A_DATA: decode = dgp_pkg::DGP_REG_A_DATA;
            `DGP_OFF_A_DIR: decode = dgp_pkg::DGP_REG_A_DIR;
            `DGP_OFF_A_PUL: decode = dgp_pkg::DGP_REG_A_PUL;
            `DGP_OFF_B_DATA: decode = dgp_pkg::DGP_REG_B_DATA;
            `DGP_OFF_B_DIR: decode = dgp_pkg::DGP_REG_B_DIR;
            `DGP_OFF_B_PUL: decode = dgp_pkg::DGP_REG_B_PUL;
            `DGP_OFF_STBY: decode = dgp_pkg::DGP_REG_STBY;
            `DGP_OFF_WAKE: decode = dgp_pkg::DGP_REG_WAKE;
            default: decode = dgp_pkg::DGP_REG_NONE;
        endcase
    endfunction

    // pin drive of one port, bit n of every vector belongs to pin n
    function automatic dgp_pkg::dgp_drive_s drive(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] poe,
        input logic [7:0] pout,
        input logic [7:0] pul,
        input logic [7:0] od,
        input logic [7:0] nopu,
        input logic hiz
    );
        dgp_pkg::dgp_drive_s d;
        d.val = (poe & pout) | (~poe & latch);
        d.en = dir | poe;
        d.en = d.en & ~(od & d.val);
        if (hiz) begin
            d.en = 8'h00;
        end
        d.pu = pul & ~nopu & ~(d.en & ~d.val);
        drive = d;
    endfunction

    // data read: latch for general outputs or rmw, pin level otherwise
    function automatic logic [7:0] read_data(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] poe,
        input logic [7:0] pin,
        input logic read_modify_write_access
    );
        logic [7:0] use_latch;
        use_latch = dir & ~poe;
        if (read_modify_write_access) begin
            read_data = latch;
        end else begin
            read_data = (use_latch & latch) | (~use_latch & pin);
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    dgp_sync_if #(.N(A_W + B_W)) sif ();

    assign sif.pin_raw = {PORT_B_PIN_I, PORT_A_PIN_I};

    dgp_pin_sync #(.N(A_W + B_W)) u_sync (
        .clk_i(CLK_SYS_I),
        .reset_n_i(RESET_N_I),
        .sif(sif)
    );

    logic [7:0] a_pin_sync;
    logic [7:0] b_pin_sync;
    assign a_pin_sync = 8'(sif.pin_sync[A_W-1:0]);
    assign b_pin_sync = 8'(sif.pin_sync[A_W+B_W-1:A_W]);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [A_W-1:0] a_latch_reg, a_latch_next;
    logic [A_W-1:0] a_dir_reg, a_dir_next;
    logic [A_W-1:0] a_pul_reg, a_pul_next;
    logic [B_W-1:0] b_latch_reg, b_latch_next;
    logic [B_W-1:0] b_dir_reg, b_dir_next;
    logic [B_W-1:0] b_pul_reg, b_pul_next;
    logic spl_reg, spl_next;
    logic [3:0] wake_reg, wake_next;
    logic dp_write_reg, dp_write_next;
    dgp_pkg::dgp_reg_e dp_sel_reg, dp_sel_next;
    logic [31:0] rdata_reg, rdata_next;

    logic addr_phase;
    dgp_pkg::dgp_reg_e addr_sel;
    logic [7:0] wbyte;
    assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign addr_sel = decode(HADDR_I[7:0]);
    assign wbyte = HWDATA_I[7:0];

    // writes land at the edge that closes the data phase
    always_comb begin
        a_latch_next = a_latch_reg;
        a_dir_next = a_dir_reg;
        a_pul_next = a_pul_reg;
        b_latch_next = b_latch_reg;
        b_dir_next = b_dir_reg;
        b_pul_next = b_pul_reg;
        spl_next = spl_reg;
        wake_next = wake_reg;
        if (dp_write_reg) begin
            case (dp_sel_reg)
                dgp_pkg::DGP_REG_A_DATA: a_latch_next = wbyte[A_W-1:0];
                dgp_pkg::DGP_REG_A_DIR: a_dir_next = wbyte[A_W-1:0];
                dgp_pkg::DGP_REG_A_PUL: a_pul_next = wbyte[A_W-1:0];
                dgp_pkg::DGP_REG_B_DATA: b_latch_next = wbyte[B_W-1:0];
                dgp_pkg::DGP_REG_B_DIR: b_dir_next = wbyte[B_W-1:0];
                dgp_pkg::DGP_REG_B_PUL: b_pul_next = wbyte[B_W-1:0];
                dgp_pkg::DGP_REG_STBY: spl_next = wbyte[`DGP_STBY_SPL_BIT];
                dgp_pkg::DGP_REG_WAKE: wake_next = wbyte[3:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus slave: zero wait, read data registered into the data phase
    // ----------------------------------------------------------------
    logic [7:0] a_rd;
    logic [7:0] b_rd;
    logic [7:0] a_in_gated;
    logic [7:0] b_in_gated;

    // next-state values are used so a read right after a write sees it
    assign a_rd = read_data(8'(a_latch_next), 8'(a_dir_next), 8'(PERIPH_A_OE_I),
        a_in_gated, READ_MODIFY_WRITE_ACCESS_I);
    assign b_rd = read_data(8'(b_latch_next), 8'(b_dir_next), 8'(PERIPH_B_OE_I),
        b_in_gated, READ_MODIFY_WRITE_ACCESS_I);

    always_comb begin
        dp_write_next = 1'b0;
        dp_sel_next = dgp_pkg::DGP_REG_NONE;
        rdata_next = 32'h0000_0000;
        if (addr_phase) begin
            dp_write_next = HWRITE_I;
            dp_sel_next = addr_sel;
            if (!HWRITE_I) begin
                case (addr_sel)
                    dgp_pkg::DGP_REG_A_DATA: rdata_next = 32'(a_rd);
                    dgp_pkg::DGP_REG_A_DIR: rdata_next = 32'(a_dir_next);
                    dgp_pkg::DGP_REG_A_PUL: rdata_next = 32'(a_pul_next);
                    dgp_pkg::DGP_REG_B_DATA: rdata_next = 32'(b_rd);
                    dgp_pkg::DGP_REG_B_DIR: rdata_next = 32'(b_dir_next);
                    dgp_pkg::DGP_REG_B_PUL: rdata_next = 32'(b_pul_next);
                    dgp_pkg::DGP_REG_STBY: rdata_next = 32'(spl_next);
                    dgp_pkg::DGP_REG_WAKE: rdata_next = 32'(wake_next);
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            a_latch_reg <= A_W'(`DGP_RST_LATCH);
            a_dir_reg <= A_W'(`DGP_RST_DIR);
            a_pul_reg <= A_W'(`DGP_RST_PUL);
            b_latch_reg <= B_W'(`DGP_RST_LATCH);
            b_dir_reg <= B_W'(`DGP_RST_DIR);
            b_pul_reg <= B_W'(`DGP_RST_PUL);
            spl_reg <= `DGP_RST_STBY;
            wake_reg <= `DGP_RST_WAKE;
            dp_write_reg <= 1'b0;
            dp_sel_reg <= dgp_pkg::DGP_REG_NONE;
            rdata_reg <= 32'h0000_0000;
        end else begin
            a_latch_reg <= a_latch_next;
            a_dir_reg <= a_dir_next;
            a_pul_reg <= a_pul_next;
            b_latch_reg <= b_latch_next;
            b_dir_reg <= b_dir_next;
            b_pul_reg <= b_pul_next;
            spl_reg <= spl_next;
            wake_reg <= wake_next;
            dp_write_reg <= dp_write_next;
            dp_sel_reg <= dp_sel_next;
            rdata_reg <= rdata_next;
        end
    end

    assign HRDATA_O = rdata_reg;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // ----------------------------------------------------------------
    // standby forcing and input gating
    // ----------------------------------------------------------------
    logic force_hiz;
    logic [7:0] b_keep;
    logic keep_sck;
    logic keep_sin;

    // with the select bit clear nothing is forced, the pins hold state
    assign force_hiz = spl_reg & STANDBY_STOP_WATCH_I;
    assign keep_sck = wake_reg[`DGP_WAKE_EIC_SCK] & wake_reg[`DGP_WAKE_SEL_SCK];
    assign keep_sin = wake_reg[`DGP_WAKE_EIC_SIN] & wake_reg[`DGP_WAKE_SEL_SIN];

    always_comb begin
        b_keep = 8'h00;
        b_keep[`DGP_B_SCK_BIT] = keep_sck;
        b_keep[`DGP_B_SIN_BIT] = keep_sin;
    end

    // blocked inputs read low so an open pin cannot leak
    assign a_in_gated = force_hiz ? 8'h00 : a_pin_sync;
    assign b_in_gated = force_hiz ? (b_pin_sync & b_keep) : b_pin_sync;

    // ----------------------------------------------------------------
    // pin outputs, registered
    // ----------------------------------------------------------------
    dgp_pkg::dgp_drive_s a_drv;
    dgp_pkg::dgp_drive_s b_drv;

    assign a_drv = drive(8'(a_latch_reg), 8'(a_dir_reg), 8'(PERIPH_A_OE_I),
        8'(PERIPH_A_OUT_I), 8'(a_pul_reg), `DGP_A_OD_MASK, `DGP_A_NOPU_MASK,
        force_hiz);
    assign b_drv = drive(8'(b_latch_reg), 8'(b_dir_reg), 8'(PERIPH_B_OE_I),
        8'(PERIPH_B_OUT_I), 8'(b_pul_reg), 8'h00, 8'h00, force_hiz);

    logic [A_W-1:0] a_o_reg, a_o_next;
    logic [A_W-1:0] a_oe_reg, a_oe_next;
    logic [A_W-1:0] a_pu_reg, a_pu_next;
    logic [A_W-1:0] a_in_reg, a_in_next;
    logic [B_W-1:0] b_o_reg, b_o_next;
    logic [B_W-1:0] b_oe_reg, b_oe_next;
    logic [B_W-1:0] b_pu_reg, b_pu_next;
    logic [B_W-1:0] b_in_reg, b_in_next;

    always_comb begin
        // open drain pins only ever drive low
        a_o_next = a_drv.val[A_W-1:0] & ~A_W'(`DGP_A_OD_MASK);
        a_oe_next = a_drv.en[A_W-1:0];
        a_pu_next = a_drv.pu[A_W-1:0];
        a_in_next = a_in_gated[A_W-1:0];
        b_o_next = b_drv.val[B_W-1:0];
        b_oe_next = b_drv.en[B_W-1:0];
        b_pu_next = b_drv.pu[B_W-1:0];
        b_in_next = b_in_gated[B_W-1:0];
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            a_o_reg <= '0;
            a_oe_reg <= '0;
            a_pu_reg <= '0;
            a_in_reg <= '0;
            b_o_reg <= '0;
            b_oe_reg <= '0;
            b_pu_reg <= '0;
            b_in_reg <= '0;
        end else begin
            a_o_reg <= a_o_next;
            a_oe_reg <= a_oe_next;
            a_pu_reg <= a_pu_next;
            a_in_reg <= a_in_next;
            b_o_reg <= b_o_next;
            b_oe_reg <= b_oe_next;
            b_pu_reg <= b_pu_next;
            b_in_reg <= b_in_next;
        end
    end

    assign PORT_A_PIN_O = a_o_reg;
    assign PORT_A_PIN_OE_O = a_oe_reg;
    assign PORT_A_PULLUP_O = a_pu_reg;
    assign PORT_A_IN_O = a_in_reg;
    assign PORT_B_PIN_O = b_o_reg;
    assign PORT_B_PIN_OE_O = b_oe_reg;
    assign PORT_B_PULLUP_O = b_pu_reg;
    assign PORT_B_IN_O = b_in_reg;
endmodule

//--- bench/dgp_top_sva.sv
// port assertions for the dual port block
`timescale 1ns/100ps
`include "dgp_defs.svh"
module dgp_top_sva #(
    parameter int A_W = 4,
    parameter int B_W = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic STANDBY_STOP_WATCH_I,
    input wire logic [B_W-1:0] PERIPH_B_OE_I,
    input wire logic [B_W-1:0] PERIPH_B_OUT_I,
    input wire logic [B_W-1:0] PORT_B_PIN_I,
    input wire logic [A_W-1:0] PORT_A_PIN_O,
    input wire logic [A_W-1:0] PORT_A_PIN_OE_O,
    input wire logic [A_W-1:0] PORT_A_PULLUP_O,
    input wire logic [A_W-1:0] PORT_A_IN_O,
    input wire logic [B_W-1:0] PORT_B_PIN_O,
    input wire logic [B_W-1:0] PORT_B_PIN_OE_O,
    input wire logic [B_W-1:0] PORT_B_PULLUP_O,
    input wire logic [B_W-1:0] PORT_B_IN_O
);
    logic wr_q;
    logic [7:0] adr_q;
    logic spl_q;
    logic hiz;
    assign hiz = spl_q & STANDBY_STOP_WATCH_I;
    // standby bit is internal, so it is rebuilt from the bus writes
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            spl_q <= 1'b0;
        end else begin
            wr_q <= HSEL_I & HTRANS_I[1] & HWRITE_I & HREADY_I;
            adr_q <= HADDR_I[7:0];
            if (wr_q && adr_q == `DGP_OFF_STBY) begin
                spl_q <= HWDATA_I[`DGP_STBY_SPL_BIT];
            end
        end
    end
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESET_N_I);
    chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus answer not ready and okay");
    chk_rdata_idle: assert property (!$past(HSEL_I & HTRANS_I[1] & !HWRITE_I)
        |-> HRDATA_O == 32'h0000_0000) else $error("read data outside read data phase");
    chk_reset_dir: assert property ($past(!RESET_N_I) |->
        PORT_A_PIN_OE_O == '0 && PORT_B_PIN_OE_O == '0) else $error("driver on after reset");
    chk_a_open_drain: assert property (PORT_A_PIN_O[1:0] == 2'h0 &&
        PORT_A_PULLUP_O[1:0] == 2'h0) else $error("open drain pin driven high or pulled");
    chk_pullup_low: assert property ((PORT_B_PULLUP_O & PORT_B_PIN_OE_O & ~PORT_B_PIN_O)
        == '0) else $error("pull-up on a pin driving low");
    chk_periph_drive: assert property ($past(RESET_N_I, 2) && !$past(hiz) |->
        (PORT_B_PIN_OE_O & $past(PERIPH_B_OE_I)) == $past(PERIPH_B_OE_I) &&
        (PORT_B_PIN_O & $past(PERIPH_B_OE_I)) == ($past(PERIPH_B_OUT_I) & $past(PERIPH_B_OE_I)))
        else $error("peripheral output not on pin");
    chk_forced_hiz: assert property ($past(hiz) |->
        PORT_A_PIN_OE_O == '0 && PORT_B_PIN_OE_O == '0) else $error("driver on in standby");
    chk_in_blocked: assert property ($past(hiz) && $past(hiz, 2) && $past(hiz, 3) |->
        PORT_A_IN_O == '0 && (PORT_B_IN_O & 8'h5F) == 8'h00) else $error("input not blocked");
    chk_pin_to_in: assert property ($past(RESET_N_I, 4) && !$past(hiz) |->
        PORT_B_IN_O == $past(PORT_B_PIN_I, 3)) else $error("internal input lags pin");
endmodule

//--- bench/dgp_board.sv
// board model resolving one port's pin levels
`timescale 1ns/100ps
module dgp_board #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] pu_i,
    input wire logic ext_en_i,
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] pin_o
);
    logic [W-1:0] drift = '0;
    // a floating line flips every cycle so a stale level never passes
    always @(posedge clk_i) drift <= ~drift;
    assign pin_o = (oe_i & out_i) | (~oe_i & (ext_en_i ? ext_i : (pu_i | drift)));
endmodule

//--- bench/dgp_top_tb.sv
// self-checking bench of the dual port block
`timescale 1ns/100ps
module dgp_top_tb;
    logic CLK_SYS_I = 1'b0;
    logic RESET_N_I = 1'b0;
    logic HSEL_I = 1'b0;
    logic HWRITE_I = 1'b0;
    logic [31:0] HADDR_I = '0, HWDATA_I = '0, HRDATA_O;
    logic [1:0] HTRANS_I = 2'h0;
    logic [2:0] HSIZE_I = 3'h2;
    logic HREADY_I, HREADYOUT_O, HRESP_O;
    logic READ_MODIFY_WRITE_ACCESS_I = 1'b0;
    logic STANDBY_STOP_WATCH_I = 1'b0;
    logic [3:0] PERIPH_A_OE_I = '0, PERIPH_A_OUT_I = '0, PORT_A_PIN_I, PORT_A_PIN_O;
    logic [3:0] PORT_A_PIN_OE_O, PORT_A_PULLUP_O, PORT_A_IN_O, ea;
    logic [7:0] PERIPH_B_OE_I = '0, PERIPH_B_OUT_I = '0, PORT_B_PIN_I, PORT_B_PIN_O;
    logic [7:0] PORT_B_PIN_OE_O, PORT_B_PULLUP_O, PORT_B_IN_O, eb, la, lb, da, db, pe, po;
    logic ext_en = 1'b1;
    logic rd_ph = 1'b0;
    int n_errors = 0, comparisons = 0, seed = 59, cyc = 0;
    logic [31:0] expq[$];
    assign HREADY_I = HREADYOUT_O;
    always #4 CLK_SYS_I = ~CLK_SYS_I;
    dgp_top #(.A_W(4), .B_W(8)) i_dut (
        .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
        .HRESP_O(HRESP_O),
        .READ_MODIFY_WRITE_ACCESS_I(READ_MODIFY_WRITE_ACCESS_I),
        .STANDBY_STOP_WATCH_I(STANDBY_STOP_WATCH_I),
        .PERIPH_A_OE_I(PERIPH_A_OE_I), .PERIPH_A_OUT_I(PERIPH_A_OUT_I),
        .PERIPH_B_OE_I(PERIPH_B_OE_I), .PERIPH_B_OUT_I(PERIPH_B_OUT_I),
        .PORT_A_PIN_I(PORT_A_PIN_I), .PORT_A_PIN_O(PORT_A_PIN_O),
        .PORT_A_PIN_OE_O(PORT_A_PIN_OE_O), .PORT_A_PULLUP_O(PORT_A_PULLUP_O),
        .PORT_A_IN_O(PORT_A_IN_O), .PORT_B_PIN_I(PORT_B_PIN_I), .PORT_B_PIN_O(PORT_B_PIN_O),
        .PORT_B_PIN_OE_O(PORT_B_PIN_OE_O), .PORT_B_PULLUP_O(PORT_B_PULLUP_O),
        .PORT_B_IN_O(PORT_B_IN_O)
    );
    dgp_board #(.W(4)) i_brd_a (.clk_i(CLK_SYS_I), .oe_i(PORT_A_PIN_OE_O), .out_i(PORT_A_PIN_O),
        .pu_i(PORT_A_PULLUP_O), .ext_en_i(1'b1), .ext_i(ea), .pin_o(PORT_A_PIN_I));
    dgp_board #(.W(8)) i_brd_b (.clk_i(CLK_SYS_I), .oe_i(PORT_B_PIN_OE_O), .out_i(PORT_B_PIN_O),
        .pu_i(PORT_B_PULLUP_O), .ext_en_i(ext_en), .ext_i(eb), .pin_o(PORT_B_PIN_I));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------
    // no wait limit of its own: only the cycle ceiling ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic m);
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HADDR_I <= {24'h00_0000, a};
        HWRITE_I <= w;
        READ_MODIFY_WRITE_ACCESS_I <= m;
        do @(posedge CLK_SYS_I); while (HREADY_I !== 1'b1);
        HTRANS_I <= 2'h0;
        HWDATA_I <= {24'h00_0000, d};
        READ_MODIFY_WRITE_ACCESS_I <= 1'b0;
        do @(posedge CLK_SYS_I); while (HREADY_I !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic m);
        expq.push_back({24'h00_0000, e});
        bus(1'b0, a, 8'h00, m);
    endtask
    // read data is judged in its data phase; also cuts a hang short
    always @(posedge CLK_SYS_I) begin
        if (rd_ph && expq.size() > 0) begin
            check("hrdata", expq.pop_front(), HRDATA_O);
        end
        rd_ph <= HSEL_I & HTRANS_I[1] & ~HWRITE_I;
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        ea = 4'($random(seed));
        eb = 8'($random(seed));
        repeat (20) @(posedge CLK_SYS_I);
        RESET_N_I <= 1'b1;
        @(posedge CLK_SYS_I);
        for (int i = 1; i < 9; i++) begin
            if (i != 3) rd(8'(i * 4), 8'h00, 1'b0);
        end
        rd(8'h00, {4'h0, ea}, 1'b0);
        rd(8'h0C, eb, 1'b0);
        check_pin("a_in", {4'h0, ea}, 8'(PORT_A_IN_O));
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            la = 8'($random(seed));
            lb = 8'($random(seed));
            da = 8'($random(seed)) & 8'h0F;
            db = 8'($random(seed));
            wr_all: begin
                bus(1'b1, 8'h00, la, 1'b0);
                bus(1'b1, 8'h0C, lb, 1'b0);
                bus(1'b1, 8'h04, da, 1'b0);
                bus(1'b1, 8'h10, db, 1'b0);
            end
            // one edge to the pin, two to sync, one into the input register
            repeat (5) @(posedge CLK_SYS_I);
            check_pin("b_oe", db, PORT_B_PIN_OE_O);
            check_pin("b_out", db & lb, db & PORT_B_PIN_O);
            check_pin("a_oe", da & ~(la & 8'h03), 8'(PORT_A_PIN_OE_O));
            check_pin("a_out", da & la & 8'h0C, da & 8'h0C & 8'(PORT_A_PIN_O));
            check_pin("b_in", (db & lb) | (~db & eb), PORT_B_IN_O);
            rd(8'h0C, (db & lb) | (~db & eb), 1'b0);
            rd(8'h0C, lb, 1'b1);
            rd(8'h00, ((da & la) | (~da & ea)) & 8'h0F, 1'b0);
            rd(8'h00, la & 8'h0F, 1'b1);
        end
        $display("port drive done");
        bus(1'b1, 8'h08, 8'h0F, 1'b0);
        bus(1'b1, 8'h14, 8'hFF, 1'b0);
        ext_en <= 1'b0;
        repeat (4) @(posedge CLK_SYS_I);
        check_pin("b_pu", ~(db & ~lb), PORT_B_PULLUP_O);
        check_pin("a_pu", 8'h0C & ~(da & ~la), 8'(PORT_A_PULLUP_O));
        rd(8'h08, 8'h0F, 1'b0);
        rd(8'h0C, (db & lb) | ~db, 1'b0);
        ext_en <= 1'b1;
        bus(1'b1, 8'h10, 8'h00, 1'b0);
        pe = 8'($random(seed));
        po = 8'($random(seed));
        PERIPH_B_OE_I <= pe;
        PERIPH_B_OUT_I <= po;
        // port a: open drain pin 0 high releases, pin 1 low drives
        PERIPH_A_OE_I <= 4'hF;
        PERIPH_A_OUT_I <= 4'h5;
        repeat (5) @(posedge CLK_SYS_I);
        check_pin("b_poe", pe, PORT_B_PIN_OE_O);
        check_pin("a_poe", 8'h0E, 8'(PORT_A_PIN_OE_O));
        check_pin("a_pout", 8'h04, 8'(PORT_A_PIN_O));
        rd(8'h0C, (pe & po) | (~pe & eb), 1'b0);
        rd(8'h0C, lb, 1'b1);
        rd(8'h00, 8'h04 | {7'h00, ea[0]}, 1'b0);
        rd(8'h00, la & 8'h0F, 1'b1);
        $display("peripheral done");
        STANDBY_STOP_WATCH_I <= 1'b1;
        repeat (4) @(posedge CLK_SYS_I);
        check_pin("b_keep", pe, PORT_B_PIN_OE_O);
        bus(1'b1, 8'h18, 8'h01, 1'b0);
        repeat (4) @(posedge CLK_SYS_I);
        check_pin("b_hiz", 8'h00, PORT_B_PIN_OE_O);
        rd(8'h0C, 8'h00, 1'b0);
        bus(1'b1, 8'h1C, 8'h0F, 1'b0);
        repeat (4) @(posedge CLK_SYS_I);
        check_pin("b_kept", eb & 8'hA0, PORT_B_IN_O);
        rd(8'h0C, eb & 8'hA0, 1'b0);
        STANDBY_STOP_WATCH_I <= 1'b0;
        repeat (4) @(posedge CLK_SYS_I);
        $display("standby done");
        end_of_test();
    end
endmodule
bind dgp_top dgp_top_sva #(.A_W(A_W), .B_W(B_W)) i_sva (.*);
